// File: include/hlt_pkg.sv
package hlt_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] HLT_ADR_CLK_SRC   = 8'h00;
   localparam logic [7:0] HLT_ADR_CONTROL   = 8'h04;
   localparam logic [7:0] HLT_ADR_HW_LIMIT  = 8'h08;
   localparam logic [7:0] HLT_ADR_RST_SEL   = 8'h0C;
   localparam logic [7:0] HLT_ADR_PERIOD    = 8'h10;
   localparam logic [7:0] HLT_ADR_COUNTER   = 8'h14;
   localparam logic [7:0] HLT_ADR_STATUS    = 8'h18;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int HLT_CTL_RUN_BIT    = 7;
   localparam int HLT_CTL_PRE_LSB    = 4;
   localparam int HLT_CTL_POST_LSB   = 0;
   localparam int HLT_HLT_PRE_SYNC_BIT = 7;
   localparam int HLT_HLT_POLARITY_BIT = 6;
   localparam int HLT_HLT_RUN_SYNC_BIT = 5;
   localparam int HLT_HLT_MODE_LSB   = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Codes and counts
   localparam logic [3:0] HLT_CLK_SRC_LAST  = 4'hA;
   localparam logic [3:0] HLT_CLK_HFINT     = 4'h3;
   localparam logic [3:0] HLT_CLK_MFINT     = 4'h5;
   localparam logic [4:0] HLT_RSEL_LAST     = 5'h11;
   localparam logic [4:0] HLT_MODE_LVL_LOW  = 5'h16;
   localparam logic [4:0] HLT_MODE_LVL_HIGH = 5'h17;
   localparam logic [1:0] HLT_SYNC_CLOCKS   = 2'h2;
   localparam logic [7:0] HLT_REG_RESET     = 8'h00;
   localparam int         HLT_CLK_SOURCES   = 11;
   localparam int         HLT_RST_SOURCES   = 18;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } hlt_wb_req_t;

   typedef struct packed {
      logic        prev;
      logic        tick;
   } hlt_edge_t;

   typedef struct packed {
      logic [3:0]  clk_src;
      logic        run;
      logic [2:0]  pre_sel;
      logic [3:0]  post_sel;
      logic        prescaler_sync_enable;
      logic        clock_polarity_select;
      logic        run_bit_sync_enable;
      logic [4:0]  mode;
      logic [4:0]  rsel;
      logic [7:0]  period;
      logic [7:0]  count;
      logic [6:0]  pre_cnt;
      logic [3:0]  post_cnt;
      logic [1:0]  sync_cnt;
      logic        clr_pending;
      logic        counting;
      logic        pre_sync_tick;
      logic        ack;
      logic [31:0] rdata;
      logic        event_out;
      logic        match_out;
      logic        drive_start;
      logic        keep_osc;
   } hlt_state_t;

endpackage : hlt_pkg

// File: design/hlt_clk_edge.sv
module hlt_clk_edge (
   // Clock and control
   input  wire logic                                ref_clk,
   input  wire logic                                sys_rst,
   input  wire logic                                ce,
   // Source selection
   input  wire logic [hlt_pkg::HLT_CLK_SOURCES-1:0] clk_sources,
   input  wire logic [3:0]                          clk_src,
   input  wire logic                                clock_polarity_select,
   // Result
   output logic                                     tick
);
   import hlt_pkg::*;

   hlt_edge_t st;
   hlt_edge_t next_st;
   logic      lvl;

   always_comb begin
      next_st = st;
      // Reserved codes give a dead clock rather than aliasing a source
      if (clk_src <= HLT_CLK_SRC_LAST) begin
         lvl = clk_sources[clk_src];
      end else begin
         lvl = 1'b0;
      end
      next_st.prev = lvl;
      next_st.tick = clock_polarity_select ? (st.prev & ~lvl) : (~st.prev & lvl);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule : hlt_clk_edge

// File: design/hlt_timer.sv
// Added by the designer: register access over Wishbone and the address map.
module hlt_timer #(
   parameter logic [4:0] OWN_POST_CODE = 5'h01
) (
   // Clock, reset, enable
   input  wire logic                                ref_clk,
   input  wire logic                                sys_rst,
   input  wire logic                                ce,
   // Wishbone slave
   input  wire hlt_pkg::hlt_wb_req_t                wb_req,
   output logic                                     wb_ack,
   output logic [31:0]                              wb_dat_o,
   // Timer sources
   input  wire logic [hlt_pkg::HLT_CLK_SOURCES-1:0] clk_sources,
   input  wire logic [hlt_pkg::HLT_RST_SOURCES-1:0] ext_rst_sources,
   input  wire logic                                sleep_mode,
   // Timer results
   output logic [7:0]                               counter_value,
   output logic                                     match_pulse,
   output logic                                     event_pulse,
   output logic                                     drive_start,
   output logic                                     run_out,
   output logic                                     osc_keep_alive
);
   import hlt_pkg::*;

   hlt_state_t s;
   hlt_state_t n;
   logic       raw_tick;
   logic       ers;
   logic       rst_lvl;
   logic       lvl_mode;
   logic       pre_out;
   logic       ptick;
   logic       enable;
   logic       access;
   logic       wr0;
   logic [6:0] pre_mask;

   ////////////////////////////////////////////////////////////////////////////////
   // Input clock edge detection
   hlt_clk_edge u_edge (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .ce          (ce),
      .clk_sources (clk_sources),
      .clk_src     (s.clk_src),
      .clock_polarity_select (s.clock_polarity_select),
      .tick        (raw_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n = s;
      n.match_out   = 1'b0;
      n.event_out   = 1'b0;
      n.drive_start = 1'b0;
      n.ack         = 1'b0;

      // External reset source; reserved and own-output codes read low
      if (s.rsel <= HLT_RSEL_LAST && s.rsel != OWN_POST_CODE) begin
         ers = ext_rst_sources[s.rsel];
      end else begin
         ers = 1'b0;
      end
      lvl_mode = (s.mode == HLT_MODE_LVL_LOW) || (s.mode == HLT_MODE_LVL_HIGH);
      rst_lvl  = (s.mode == HLT_MODE_LVL_HIGH) ? ers : ~ers;

      // Prescaler: ratio 2^code, taken from the low bits of a free count
      pre_mask = 7'((8'h01 << s.pre_sel) - 8'h01);
      pre_out  = raw_tick && ((s.pre_cnt & pre_mask) == pre_mask);
      if (raw_tick && s.run) begin
         n.pre_cnt = s.pre_cnt + 7'h01;
      end

      // Retiming costs one cycle of latency but keeps counter reads coherent
      n.pre_sync_tick = pre_out;
      ptick = s.prescaler_sync_enable ? s.pre_sync_tick : pre_out;
      if (s.prescaler_sync_enable && sleep_mode) begin
         ptick = 1'b0;
      end

      // Run synchronisation: wait two input clocks after run is set
      if (s.run && s.sync_cnt != 2'h0 && raw_tick) begin
         n.sync_cnt = s.sync_cnt - 2'h1;
      end
      enable = s.run && (s.sync_cnt == 2'h0);

      // Counter and match
      if (lvl_mode) begin
         // Run clear holds the counter at zero; external level ignored while off
         if (!s.run) begin
            n.count       = 8'h00;
            n.clr_pending = 1'b0;
            n.counting    = 1'b0;
         end else if (rst_lvl) begin
            n.count       = 8'h00;
            n.clr_pending = 1'b0;
            n.counting    = 1'b0;
         end else if (enable) begin
            n.counting = 1'b1;
            if (!s.counting) begin
               n.drive_start = 1'b1;
            end
            if (ptick) begin
               if (s.count == s.period) begin
                  n.count     = 8'h00;
                  n.run       = 1'b0;
                  n.counting  = 1'b0;
                  n.match_out = 1'b1;
               end else begin
                  n.count = s.count + 8'h01;
               end
            end
         end
      end else begin
         n.counting = enable;
         if (enable && !s.counting) begin
            n.drive_start = 1'b1;
         end
         // Stopping leaves the counter where it was
         if (enable && ptick) begin
            if (s.count == s.period) begin
               n.count       = 8'h00;
               n.clr_pending = 1'b0;
               n.match_out   = 1'b1;
            end else begin
               n.count = s.count + 8'h01;
            end
         end
      end

      // Postscaler on match events
      if (n.match_out) begin
         if (s.post_cnt == s.post_sel) begin
            n.post_cnt  = 4'h0;
            n.event_out = 1'b1;
         end else begin
            n.post_cnt = s.post_cnt + 4'h1;
         end
      end

      // Run clear resets prescaler, postscaler and sync state
      if (!s.run) begin
         n.pre_cnt    = 7'h00;
         n.post_cnt   = 4'h0;
         n.pre_sync_tick = 1'b0;
         n.sync_cnt   = s.run_bit_sync_enable ? HLT_SYNC_CLOCKS : 2'h0;
         n.counting   = 1'b0;
      end

      // Internal oscillators stay on when chosen as the timer clock
      n.keep_osc = (s.clk_src >= HLT_CLK_HFINT) && (s.clk_src <= HLT_CLK_MFINT);

      ////////////////////////////////////////////////////////////////////////////
      // Wishbone slave: one wait state, ack for one cycle
      access = wb_req.cyc && wb_req.stb && !s.ack;
      wr0    = access && wb_req.we && wb_req.sel[0];
      if (access) begin
         n.ack = 1'b1;
         case (wb_req.adr)
            HLT_ADR_CLK_SRC:  n.rdata = {28'h0000000, s.clk_src};
            HLT_ADR_CONTROL:  n.rdata = {24'h000000, s.run, s.pre_sel, s.post_sel};
            HLT_ADR_HW_LIMIT: n.rdata = {24'h000000, s.prescaler_sync_enable,
                                         s.clock_polarity_select, s.run_bit_sync_enable,
                                         s.mode};
            HLT_ADR_RST_SEL:  n.rdata = {27'h0000000, s.rsel};
            HLT_ADR_PERIOD:   n.rdata = {24'h000000, s.period};
            HLT_ADR_COUNTER:  n.rdata = {24'h000000, s.count};
            HLT_ADR_STATUS:   n.rdata = {28'h0000000, rst_lvl, ers, s.sync_cnt != 2'h0,
                                         s.counting};
            default:          n.rdata = 32'h00000000;
         endcase
      end else begin
         n.rdata = 32'h00000000;
      end

      // Software write lands after the hardware clear, so a set is never lost
      if (wr0) begin
         case (wb_req.adr)
            HLT_ADR_CLK_SRC: begin
               n.clk_src = wb_req.dat[3:0];
            end
            HLT_ADR_CONTROL: begin
               n.run      = wb_req.dat[HLT_CTL_RUN_BIT];
               n.pre_sel  = wb_req.dat[HLT_CTL_PRE_LSB +: 3];
               n.post_sel = wb_req.dat[HLT_CTL_POST_LSB +: 4];
            end
            HLT_ADR_HW_LIMIT: begin
               // Polarity changes while running can produce a stray edge
               n.prescaler_sync_enable = wb_req.dat[HLT_HLT_PRE_SYNC_BIT];
               n.clock_polarity_select = wb_req.dat[HLT_HLT_POLARITY_BIT];
               n.run_bit_sync_enable   = wb_req.dat[HLT_HLT_RUN_SYNC_BIT];
               n.mode   = wb_req.dat[HLT_HLT_MODE_LSB +: 5];
            end
            HLT_ADR_RST_SEL: begin
               n.rsel = wb_req.dat[4:0];
            end
            HLT_ADR_PERIOD: begin
               n.period = wb_req.dat[7:0];
            end
            HLT_ADR_COUNTER: begin
               n.count       = wb_req.dat[7:0];
               n.clr_pending = 1'b0;
            end
            default: begin
               n.period = n.period;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s        <= '0;
         s.period <= HLT_REG_RESET;
      end else if (ce) begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register
   assign wb_ack         = s.ack;
   assign wb_dat_o       = s.rdata;
   assign counter_value  = s.count;
   assign match_pulse    = s.match_out;
   assign event_pulse    = s.event_out;
   assign drive_start    = s.drive_start;
   assign run_out        = s.run;
   assign osc_keep_alive = s.keep_osc;

endmodule : hlt_timer

// File: verification/hlt_timer_asserts.sv
module hlt_timer_asserts (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 sys_rst,
   input wire logic                 ce,
   // Bus side
   input wire hlt_pkg::hlt_wb_req_t wb_req,
   input wire logic                 wb_ack,
   input wire logic [31:0]          wb_dat_o,
   // Timer side
   input wire logic [17:0]          ext_rst_sources,
   input wire logic                 sleep_mode,
   input wire logic [7:0]           counter_value,
   input wire logic                 match_pulse,
   input wire logic                 drive_start,
   input wire logic                 run_out,
   input wire logic                 osc_keep_alive
);
   timeunit 1ns;
   timeprecision 1ns;
   import hlt_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // Shadow of the mode byte; the bench feeds every reset candidate one level
   logic [7:0] hw;
   logic       keep;
   wire        wr = wb_ack && wb_req.cyc && wb_req.we && wb_req.sel[0];
   wire        lvl = hw[4:0] == HLT_MODE_LVL_LOW || hw[4:0] == HLT_MODE_LVL_HIGH;
   wire        at_lvl = ext_rst_sources[0] == hw[0];
   wire        zero = counter_value == 8'h00;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hw   <= 8'h00;
         keep <= 1'b0;
      end else if (wr && wb_req.adr == HLT_ADR_HW_LIMIT) begin
         hw   <= wb_req.dat[7:0];
      end else if (wr && wb_req.adr == HLT_ADR_CLK_SRC) begin
         keep <= wb_req.dat[3:0] inside {[HLT_CLK_HFINT:HLT_CLK_MFINT]};
      end
   end
   sequence s_asleep;
      (sleep_mode && hw[7])[*5];
   endsequence
   sequence s_held;
      (lvl && (at_lvl || !run_out))[*4];
   endsequence
   AST_ACK_NEXT: assert property (wb_req.cyc && wb_req.stb && !wb_ack && ce |=> wb_ack)
      else $error("bus request left unanswered");
   AST_ACK_ONCE: assert property (wb_ack && ce |=> !wb_ack) else $error("answer held");
   AST_DATA_IDLE: assert property (!wb_ack |-> wb_dat_o == 32'h0) else $error("stray data");
   AST_HIGH_ZERO: assert property (wb_ack |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> !run_out && zero)
      else $error("state left after reset");
   AST_LVL_HOLD: assert property (s_held |-> zero) else $error("count not held");
   AST_LVL_MATCH: assert property (lvl && match_pulse |-> zero && !run_out)
      else $error("match did not stop timer");
   // The first count step may coincide with the start pulse, so look at the held value
   AST_START: assert property (lvl && drive_start |-> run_out && $past(zero))
      else $error("bad start");
   AST_SLEEP_HOLD: assert property (s_asleep |=> $stable(counter_value))
      else $error("count moved in sleep");
   AST_OSC_KEEP: assert property (osc_keep_alive == keep)
      else $error("oscillator hold wrong");
endmodule : hlt_timer_asserts
bind hlt_timer hlt_timer_asserts u_chk (
   .ref_clk, .sys_rst, .ce, .wb_req, .wb_ack, .wb_dat_o, .ext_rst_sources, .sleep_mode,
   .counter_value, .match_pulse, .drive_start, .run_out, .osc_keep_alive
);

// File: verification/hlt_far_model.sv
module hlt_far_model (
   // Clock
   input  wire logic ref_clk,
   // Level asked for by the bench
   input  wire logic ext_level,
   // Sources at the timer
   output logic [10:0] clk_sources,
   output logic [17:0] ext_rst_sources
);
   timeunit 1ns;
   timeprecision 1ns;
   import hlt_pkg::*;
   ////////////////////////////////////////
   logic [1:0] div = 2'h0;
   // Oscillators run free; a quarter rate keeps every edge visible
   always @(posedge ref_clk) begin
      div             <= div + 2'h1;
      ext_rst_sources <= {HLT_RST_SOURCES{ext_level}};
   end
   assign clk_sources = {HLT_CLK_SOURCES{div[1]}};
endmodule : hlt_far_model

// File: verification/hlt_timer_bench.sv
module hlt_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import hlt_pkg::*;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wdat;
      logic [7:0] want;
   } hlt_row_t;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        sleep_mode = 1'b0;
   logic        ext_level = 1'b0;
   logic        wb_ack, match_pulse, event_pulse, drive_start, run_out;
   logic [2:0]  watch;
   logic [7:0]  c0, counter_value;
   logic [10:0] clk_sources;
   logic [17:0] ext_rst_sources;
   logic [31:0] wb_dat_o, rd;
   hlt_wb_req_t wb_req = '0;
   int          err_total = 0;
   int          comparisons = 0;
   int          m, e;
   hlt_row_t    rows [9] = '{'{HLT_ADR_CLK_SRC, 8'hFF, 8'h0F}, '{HLT_ADR_CLK_SRC, 8'h03, 8'h03},
      '{HLT_ADR_CONTROL, 8'h7F, 8'h7F}, '{HLT_ADR_HW_LIMIT, 8'hFF, 8'hFF},
      '{HLT_ADR_RST_SEL, 8'hFF, 8'h1F}, '{HLT_ADR_RST_SEL, 8'h01, 8'h01},
      '{HLT_ADR_RST_SEL, 8'h11, 8'h11}, '{8'h1C, 8'hFF, 8'h00}, '{HLT_ADR_PERIOD, 8'hAB, 8'hAB}};
   ////////////////////////////////////////
   always #20 ref_clk = ~ref_clk;
   assign watch = {wb_ack, run_out, drive_start};
   hlt_timer u_dut (
      .ref_clk, .sys_rst, .ce(1'b1), .wb_req, .wb_ack, .wb_dat_o, .clk_sources,
      .ext_rst_sources, .sleep_mode, .counter_value, .match_pulse, .event_pulse,
      .drive_start, .run_out, .osc_keep_alive()
   );
   hlt_far_model u_far (.ref_clk, .ext_level, .clk_sources, .ext_rst_sources);
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d wrong %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   // Bounded wait; a hang ends the run at once
   task automatic await(input int idx, input logic val, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (watch[idx] !== val && n < lim);
      if (watch[idx] !== val) begin
         err_total++;
         wrap_up();
      end
   endtask : await
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      @(posedge ref_clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h0, dat}};
      await(2, 1'b1, 20);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask : bus
   // Run bit goes last, so polarity never changes while running
   task automatic cfg(input logic [7:0] hw, input logic [7:0] per, input logic [7:0] con);
      logic [7:0] a [7];
      logic [7:0] d [7];
      a = '{HLT_ADR_CONTROL, HLT_ADR_COUNTER, HLT_ADR_CLK_SRC, HLT_ADR_PERIOD,
            HLT_ADR_RST_SEL, HLT_ADR_HW_LIMIT, HLT_ADR_CONTROL};
      d = '{8'h00, 8'h00, 8'h01, per, 8'h00, hw, con};
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, a[i], d[i]);
      end
   endtask : cfg
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 8'(4 * i), 8'h00);
         check(rd, 32'h0);
      end
      foreach (rows[i]) begin
         bus(1'b1, rows[i].adr, rows[i].wdat);
         bus(1'b0, rows[i].adr, 8'h00);
         check(rd, {24'h0, rows[i].want});
      end
      for (int p = 0; p < 3; p++) begin
         cfg(8'h00, 8'h02, {1'b1, 3'(p), 4'h1});
         m = 0;
         e = 0;
         repeat (768) begin
            @(posedge ref_clk);
            m += match_pulse;
            e += event_pulse;
         end
         check(m == (64 >> p) || m == (64 >> p) - 1, 1);
         check(e == m / 2 || e == (m + 1) / 2, 1);
         bus(1'b1, HLT_ADR_CONTROL, 8'h00);
         bus(1'b0, HLT_ADR_COUNTER, 8'h00);
         c0 = rd[7:0];
         repeat (20) @(posedge ref_clk);
         bus(1'b0, HLT_ADR_COUNTER, 8'h00);
         check(rd[7:0], c0);
      end
      for (int s = 1; s >= 0; s--) begin
         cfg({s[0], 7'h00}, 8'hFF, 8'h80);
         repeat (8) @(posedge ref_clk);
         sleep_mode <= 1'b1;
         repeat (8) @(posedge ref_clk);
         bus(1'b0, HLT_ADR_COUNTER, 8'h00);
         c0 = rd[7:0];
         repeat (40) @(posedge ref_clk);
         bus(1'b0, HLT_ADR_COUNTER, 8'h00);
         check(rd[7:0] == c0, s[0]);
         sleep_mode <= 1'b0;
      end
      // Run sync: still waiting right after run, counting after two input clocks
      cfg(8'h20, 8'hFF, 8'h80);
      bus(1'b0, HLT_ADR_STATUS, 8'h00);
      check(rd[1], 1'b1);
      repeat (20) @(posedge ref_clk);
      bus(1'b0, HLT_ADR_STATUS, 8'h00);
      check(rd[1:0], 2'h1);
      // Both reset levels, each with either condition arriving last
      for (int k = 0; k < 4; k++) begin
         ext_level <= k[0] ^ !k[1];
         cfg({3'h0, HLT_MODE_LVL_LOW[4:1], k[0]}, 8'h03, 8'h80);
         if (k[1]) begin
            repeat (20) @(posedge ref_clk);
            check(counter_value, 8'h00);
            check(run_out, 1'b1);
            ext_level <= !k[0];
         end
         await(0, 1'b1, 40);
         await(1, 1'b0, 100);
         check(counter_value, 8'h00);
         repeat (30) @(posedge ref_clk);
         check(counter_value, 8'h00);
         bus(1'b0, HLT_ADR_CONTROL, 8'h00);
         check(rd[7], 1'b0);
      end
      wrap_up();
   end
endmodule : hlt_timer_bench
